// ### core/rdr_refresh.sv
// Display refresh fetch and pixel output path with APB register slave.
// Assumes a synchronous display buffer on i_mclk: data one cycle after read.
//
// The placing of the registers and the APB slave port are this design's own decisions.
module rdr_refresh (
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_mem_rd,
    output logic      [16:0]       o_mem_addr,
    input  wire logic [7:0]        i_mem_data,
    output logic                   o_pix_valid,
    output rdr_pkg::rdr_pix_t      o_pix,
    output logic                   o_line_end,
    output logic                   o_frame_end
);
    `include "rdr_regs.svh"

    rdr_pkg::rdr_rot_mode_t rot_mode_ff;
    rdr_pkg::rdr_state_t    st_ff;
    rdr_pkg::rdr_depth_t    depth;
    rdr_pkg::rdr_pix_t      lut_pix;
    rdr_pkg::rdr_pix_t      nxt_pix;
    logic [7:0]             stride_ff;
    logic [16:0]            start_ff;
    logic [5:0]             ctrl_ff;
    logic [6:0]             panel_w_ff;
    logic [9:0]             panel_h_ff;
    logic [7:0]             split_ff;
    logic [7:0]             lut_idx_ff;
    logic [11:0]            lut_mem [0:255];
    logic [31:0]            prdata_ff;
    logic                   slverr_ff;
    logic [9:0]             hcnt_ff;
    logic [9:0]             vcnt_ff;
    logic [2:0]             sub_ff;
    logic [16:0]            addr_ff;
    logic [16:0]            line_addr_ff;
    logic [7:0]             byte_ff;
    logic                   pix_valid_ff;
    logic                   line_end_ff;
    logic                   frame_end_ff;
    logic [11:0]            pix_ff;
    logic [7:0]             idx;
    logic                   mapped;
    logic                   wr_en;
    logic                   setup;
    logic                   rot_en;
    logic                   alt_rot;
    logic                   dflt_rot;
    logic                   disp_en;
    logic [8:0]             stride_eff;
    logic [16:0]            eff_start;
    logic [2:0]             ppb_m1;
    logic [10:0]            row_bytes;
    logic [1:0]             pix_sel;
    logic [1:0]             mem_sel;
    logic                   pix_tick;
    logic                   mem_tick;
    logic                   adv;
    logic                   frame_init;
    logic                   line_end;
    logic                   frame_end;
    logic [2:0]             sh;
    logic [7:0]             pix_idx;
    logic [7:0]             pix_mask;
    logic [16:0]            nxt_line;

    // APB decode; upper address bits must be zero for a hit
    assign idx    = i_paddr[9:2];
    assign setup  = i_psel && !i_penable;
    assign wr_en  = i_psel && i_penable && i_pwrite && mapped;

    always_comb
    begin
        mapped = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
        unique case (idx)
            `RDR_IDX_START_LO, `RDR_IDX_START_HI, `RDR_IDX_ROT_MODE,
            `RDR_IDX_STRIDE, `RDR_IDX_DISP_CTRL, `RDR_IDX_PANEL_W,
            `RDR_IDX_PANEL_H_LO, `RDR_IDX_PANEL_H_HI, `RDR_IDX_SPLIT_LINE,
            `RDR_IDX_LUT_INDEX, `RDR_IDX_LUT_DATA, `RDR_IDX_STATUS: ;
            default: mapped = 1'b0;
        endcase
    end

    // Read data registered in setup so the access phase answers at once
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            prdata_ff <= 32'h0;
            slverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            slverr_ff <= !mapped;
            unique case (idx)
                `RDR_IDX_START_LO:   prdata_ff <= {24'h0, start_ff[7:0]};
                `RDR_IDX_START_HI:   prdata_ff <= {23'h0, start_ff[16:8]};
                `RDR_IDX_ROT_MODE:   prdata_ff <= {24'h0, rot_mode_ff};
                `RDR_IDX_STRIDE:     prdata_ff <= {24'h0, stride_ff};
                `RDR_IDX_DISP_CTRL:  prdata_ff <= {26'h0, ctrl_ff};
                `RDR_IDX_PANEL_W:    prdata_ff <= {25'h0, panel_w_ff};
                `RDR_IDX_PANEL_H_LO: prdata_ff <= {24'h0, panel_h_ff[7:0]};
                `RDR_IDX_PANEL_H_HI: prdata_ff <= {30'h0, panel_h_ff[9:8]};
                `RDR_IDX_SPLIT_LINE: prdata_ff <= {24'h0, split_ff};
                `RDR_IDX_LUT_INDEX:  prdata_ff <= {24'h0, lut_idx_ff};
                `RDR_IDX_LUT_DATA:   prdata_ff <= {20'h0, lut_mem[lut_idx_ff]};
                `RDR_IDX_STATUS:     prdata_ff <= {15'h0, (st_ff != rdr_pkg::RDR_ST_IDLE),
                                                   6'h0, vcnt_ff};
                default:             prdata_ff <= 32'h0;
            endcase
            // Refused reads answer zero, even when the index itself is mapped
            if (!mapped)
                prdata_ff <= 32'h0;
        end
    end

    assign o_prdata  = prdata_ff;
    assign o_pready  = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && slverr_ff;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            rot_mode_ff <= `RDR_RST_ROT_MODE;
            stride_ff   <= `RDR_RST_STRIDE;
            start_ff    <= `RDR_RST_START;
            ctrl_ff     <= `RDR_RST_CTRL;
            panel_w_ff  <= `RDR_RST_PANEL_W;
            panel_h_ff  <= `RDR_RST_PANEL_H;
            split_ff    <= `RDR_RST_SPLIT;
        end
        else if (wr_en)
        begin
            unique case (idx)
                `RDR_IDX_START_LO:   start_ff[7:0]    <= i_pwdata[7:0];
                `RDR_IDX_START_HI:   start_ff[16:8]   <= i_pwdata[8:0];
                `RDR_IDX_ROT_MODE:   rot_mode_ff      <= i_pwdata[7:0] & `RDR_ROT_WR_MASK;
                `RDR_IDX_STRIDE:     stride_ff        <= i_pwdata[7:0];
                `RDR_IDX_DISP_CTRL:  ctrl_ff          <= i_pwdata[5:0];
                `RDR_IDX_PANEL_W:    panel_w_ff       <= i_pwdata[6:0];
                `RDR_IDX_PANEL_H_LO: panel_h_ff[7:0]  <= i_pwdata[7:0];
                `RDR_IDX_PANEL_H_HI: panel_h_ff[9:8]  <= i_pwdata[1:0];
                `RDR_IDX_SPLIT_LINE: split_ff         <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Table data writes auto-advance the index for burst loading
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            lut_idx_ff <= `RDR_RST_LUT_INDEX;
        else if (wr_en && idx == `RDR_IDX_LUT_INDEX)
            lut_idx_ff <= i_pwdata[7:0];
        else if (wr_en && idx == `RDR_IDX_LUT_DATA)
            lut_idx_ff <= lut_idx_ff + 8'h01;
    end

    always_ff @(posedge i_mclk)
    begin
        if (wr_en && idx == `RDR_IDX_LUT_DATA)
            lut_mem[lut_idx_ff] <= i_pwdata[11:0];
    end

    // Mode decode and address arithmetic
    assign rot_en     = rot_mode_ff.rotation_enable;
    assign alt_rot    = rot_en && rot_mode_ff.rotation_variant_select;
    assign dflt_rot   = rot_en && !rot_mode_ff.rotation_variant_select;
    assign disp_en    = ctrl_ff[`RDR_CTRL_EN_BIT];
    assign depth      = rdr_pkg::rdr_depth_t'(ctrl_ff[`RDR_CTRL_DEPTH_LSB +: 2]);
    assign stride_eff = (stride_ff == 8'h00) ? `RDR_STRIDE_ZERO : {1'b0, stride_ff};
    // Pans are plain start offsets: +1 byte, +stride or +2*stride
    assign eff_start  = start_ff;
    assign ppb_m1     = 3'((4'h8 >> depth) - 4'h1);
    assign row_bytes  = 11'(({4'h0, panel_w_ff} + 11'h001) << depth);

    always_comb
    begin
        pix_sel = 2'h0;
        mem_sel = 2'h0;
        if (dflt_rot)
        begin
            pix_sel = rot_mode_ff.clk_sel;
            mem_sel = rot_mode_ff.clk_sel;
        end
        else if (alt_rot)
        begin
            // Memory runs one octave above pixel rate for the extra fetch
            pix_sel = (rot_mode_ff.clk_sel == 2'h0) ? 2'h1 : rot_mode_ff.clk_sel;
            mem_sel = pix_sel - 2'h1;
        end
    end

    rdr_clkdiv u_pix_div (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .i_sel  (pix_sel),
        .o_tick (pix_tick)
    );

    rdr_clkdiv u_mem_div (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .i_sel  (mem_sel),
        .o_tick (mem_tick)
    );

    assign adv        = (st_ff == rdr_pkg::RDR_ST_SHOW) && pix_tick;
    assign line_end   = (hcnt_ff == {panel_w_ff, 3'h7});
    assign frame_end  = line_end && (vcnt_ff == panel_h_ff);
    assign frame_init = ((st_ff == rdr_pkg::RDR_ST_IDLE) && disp_en) || (adv && frame_end);
    assign o_mem_rd   = (st_ff == rdr_pkg::RDR_ST_FETCH) && mem_tick;
    assign o_mem_addr = addr_ff;

    // Refresh sequencing: fetch a byte, then show pixels from it
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            st_ff <= rdr_pkg::RDR_ST_IDLE;
        else
        begin
            unique case (st_ff)
                rdr_pkg::RDR_ST_IDLE:
                    if (disp_en)
                        st_ff <= rdr_pkg::RDR_ST_FETCH;
                rdr_pkg::RDR_ST_FETCH:
                    if (!disp_en)
                        st_ff <= rdr_pkg::RDR_ST_IDLE;
                    else if (mem_tick)
                        st_ff <= rdr_pkg::RDR_ST_WAIT;
                rdr_pkg::RDR_ST_WAIT:
                    st_ff <= rdr_pkg::RDR_ST_SHOW;
                rdr_pkg::RDR_ST_SHOW:
                    if (!disp_en)
                        st_ff <= rdr_pkg::RDR_ST_IDLE;
                    else if (pix_tick && (rot_en || line_end || sub_ff == ppb_m1))
                        st_ff <= rdr_pkg::RDR_ST_FETCH;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            byte_ff <= 8'h00;
        else if (st_ff == rdr_pkg::RDR_ST_WAIT)
            byte_ff <= i_mem_data;
    end

    // Landscape line start, with split screen only outside rotation
    always_comb
    begin
        nxt_line = line_addr_ff + {6'h00, row_bytes};
        if (!rot_en && ctrl_ff[`RDR_CTRL_SPLIT_BIT]
            && (vcnt_ff + 10'h001) == {2'h0, split_ff})
            nxt_line = 17'h00000;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            hcnt_ff      <= 10'h000;
            vcnt_ff      <= 10'h000;
            sub_ff       <= 3'h0;
            addr_ff      <= 17'h00000;
            line_addr_ff <= 17'h00000;
        end
        else if (frame_init)
        begin
            hcnt_ff      <= 10'h000;
            vcnt_ff      <= 10'h000;
            sub_ff       <= 3'h0;
            addr_ff      <= eff_start;
            line_addr_ff <= eff_start;
        end
        else if (adv && line_end)
        begin
            hcnt_ff <= 10'h000;
            vcnt_ff <= vcnt_ff + 10'h001;
            if (rot_en && sub_ff == ppb_m1)
            begin
                sub_ff       <= 3'h0;
                line_addr_ff <= line_addr_ff - 17'h00001;
                addr_ff      <= line_addr_ff - 17'h00001;
            end
            else if (rot_en)
            begin
                sub_ff  <= sub_ff + 3'h1;
                addr_ff <= line_addr_ff;
            end
            else
            begin
                sub_ff       <= 3'h0;
                line_addr_ff <= nxt_line;
                addr_ff      <= nxt_line;
            end
        end
        else if (adv)
        begin
            hcnt_ff <= hcnt_ff + 10'h001;
            if (rot_en)
                addr_ff <= addr_ff + {8'h00, stride_eff};
            else if (sub_ff == ppb_m1)
            begin
                sub_ff  <= 3'h0;
                addr_ff <= addr_ff + 17'h00001;
            end
            else
                sub_ff <= sub_ff + 3'h1;
        end
    end

    // Pixel select: rotation walks a byte right to left across lines
    always_comb
    begin
        sh = 3'((rot_en ? sub_ff : (ppb_m1 - sub_ff)) << depth);
        unique case (depth)
            rdr_pkg::RDR_BPP1: pix_mask = 8'h01;
            rdr_pkg::RDR_BPP2: pix_mask = 8'h03;
            rdr_pkg::RDR_BPP4: pix_mask = 8'h0F;
            rdr_pkg::RDR_BPP8: pix_mask = 8'hFF;
        endcase
        pix_idx = (byte_ff >> sh) & pix_mask;
        lut_pix = rdr_pkg::rdr_pix_t'(lut_mem[pix_idx]);
        nxt_pix = lut_pix;
        if (!ctrl_ff[`RDR_CTRL_COLOUR_BIT])
            nxt_pix = '{red: lut_pix.green, green: lut_pix.green, blue: lut_pix.green};
        if (ctrl_ff[`RDR_CTRL_INV_BIT])
            nxt_pix = ~nxt_pix;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            pix_valid_ff <= 1'b0;
            line_end_ff  <= 1'b0;
            frame_end_ff <= 1'b0;
            pix_ff       <= 12'h000;
        end
        else
        begin
            pix_valid_ff <= adv;
            line_end_ff  <= adv && line_end;
            frame_end_ff <= adv && frame_end;
            if (adv)
                pix_ff <= nxt_pix;
        end
    end

    assign o_pix_valid = pix_valid_ff;
    assign o_pix       = rdr_pkg::rdr_pix_t'(pix_ff);
    assign o_line_end  = line_end_ff;
    assign o_frame_end = frame_end_ff;
endmodule // rdr_refresh

// ### shared/rdr_regs.svh
// Register indices, field positions, reset values of the refresh path.
// Assumes APB byte address = index * 4, one 32-bit word per register.
`ifndef RDR_REGS_SVH
`define RDR_REGS_SVH

`define RDR_IDX_START_LO    8'h0C
`define RDR_IDX_START_HI    8'h10
`define RDR_IDX_ROT_MODE    8'h1B
`define RDR_IDX_STRIDE      8'h1C
`define RDR_IDX_DISP_CTRL   8'h20
`define RDR_IDX_PANEL_W     8'h21
`define RDR_IDX_PANEL_H_LO  8'h22
`define RDR_IDX_PANEL_H_HI  8'h23
`define RDR_IDX_SPLIT_LINE  8'h24
`define RDR_IDX_LUT_INDEX   8'h25
`define RDR_IDX_LUT_DATA    8'h26
`define RDR_IDX_STATUS      8'h27

`define RDR_ROT_EN_BIT      7
`define RDR_ROT_VAR_BIT     6
`define RDR_ROT_WR_MASK     8'hC3

`define RDR_CTRL_INV_BIT    0
`define RDR_CTRL_DEPTH_LSB  1
`define RDR_CTRL_COLOUR_BIT 3
`define RDR_CTRL_SPLIT_BIT  4
`define RDR_CTRL_EN_BIT     5
`define RDR_STATUS_BUSY_BIT 16

`define RDR_RST_ROT_MODE    8'h00
`define RDR_RST_STRIDE      8'h00
`define RDR_RST_START       17'h00000
`define RDR_RST_CTRL        6'h00
`define RDR_RST_PANEL_W     7'h27
`define RDR_RST_PANEL_H     10'h0EF
`define RDR_RST_SPLIT       8'hFF
`define RDR_RST_LUT_INDEX   8'h00

`define RDR_STRIDE_ZERO     9'h100

`endif

// ### shared/rdr_pkg.sv
// Types shared by the refresh path modules.
// Assumes rdr_regs.svh supplies all numeric constants.
package rdr_pkg;

    typedef enum logic [1:0] {
        RDR_BPP1,
        RDR_BPP2,
        RDR_BPP4,
        RDR_BPP8
    } rdr_depth_t;

    typedef enum logic [1:0] {
        RDR_ST_IDLE,
        RDR_ST_FETCH,
        RDR_ST_WAIT,
        RDR_ST_SHOW
    } rdr_state_t;

    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } rdr_pix_t;

    typedef struct packed {
        logic       rotation_enable;
        logic       rotation_variant_select;
        logic [3:0] unused;
        logic [1:0] clk_sel;
    } rdr_rot_mode_t;

endpackage

// ### core/rdr_clkdiv.sv
// Divide-by-2^sel tick generator for pixel and memory pacing.
// Assumes sel changes only while the refresh path is idle or between frames.
module rdr_clkdiv (
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);
    logic [2:0] cnt_ff;
    logic [2:0] mask;

    always_comb
    begin
        mask = 3'((4'h1 << i_sel) - 4'h1);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst || ((cnt_ff & mask) == mask))
            cnt_ff <= 3'h0;
        else
            cnt_ff <= cnt_ff + 3'h1;
    end

    assign o_tick = ((cnt_ff & mask) == mask);
endmodule // rdr_clkdiv

// ### verif/rdr_refresh_sva.sv
// Port-level checker for the display refresh path.
// Assumes it is bound to rdr_refresh and sees only that module's ports.
module rdr_refresh_sva (
    input wire logic              i_mclk,
    input wire logic              i_srst,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [11:0]       i_paddr,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire logic              o_mem_rd,
    input wire logic              o_pix_valid,
    input wire rdr_pkg::rdr_pix_t o_pix,
    input wire logic              o_line_end,
    input wire logic              o_frame_end
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    logic acc;
    assign acc = i_psel && i_penable;

    pready_zero_wait_a: assert property (acc |-> o_pready)
        else $error("pready low in access phase");
    pready_idle_a: assert property (!acc |-> !o_pready)
        else $error("pready high outside access phase");
    slverr_access_a: assert property (o_pslverr |-> acc)
        else $error("pslverr outside access phase");
    unaligned_err_a: assert property (acc && i_paddr[1:0] != 2'h0 |-> o_pslverr)
        else $error("unaligned access not refused");
    miss_read_zero_a: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
        else $error("refused read returned data");
    fetch_spacing_a: assert property (o_mem_rd |=> !o_mem_rd [*2])
        else $error("buffer reads closer than fetch, wait, show");
    pix_hold_a: assert property (!$past(i_srst) && o_pix != $past(o_pix) |-> o_pix_valid)
        else $error("pixel changed without valid");
    line_end_pix_a: assert property (o_line_end |-> o_pix_valid)
        else $error("line end without pixel");
    frame_end_line_a: assert property (o_frame_end |-> o_line_end)
        else $error("frame end without line end");
endmodule // rdr_refresh_sva

bind rdr_refresh rdr_refresh_sva u_sva (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem_rd(o_mem_rd),
    .o_pix_valid(o_pix_valid), .o_pix(o_pix), .o_line_end(o_line_end),
    .o_frame_end(o_frame_end));

// ### verif/rdr_buf_model.sv
// Display buffer model: each byte is a pattern of its own address.
// Assumes reads are one-cycle strobes sampled on the rising edge.
module rdr_buf_model (
    input  wire logic        i_mclk,
    input  wire logic        i_mem_rd,
    input  wire logic [16:0] i_mem_addr,
    output logic      [7:0]  o_mem_data
);
    // Toggles outside the answer cycle so stale data never looks valid
    always_ff @(posedge i_mclk)
        if (i_mem_rd)
            o_mem_data <= i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ {7'h00, i_mem_addr[16]};
        else
            o_mem_data <= ~o_mem_data;
endmodule // rdr_buf_model

// ### verif/rotated_display_refresh_path_tb.sv
// Self-checking bench: APB register access and refreshed pixel stream.
// Assumes rdr_buf_model answers buffer reads one cycle after the strobe.
`include "rdr_regs.svh"
`define RDR_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module rotated_display_refresh_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              i_mclk = 1'b0;
    logic              i_srst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready, pslverr, mem_rd, pix_valid, line_end, frame_end;
    logic [16:0]       mem_addr;
    logic [7:0]        mem_data;
    rdr_pkg::rdr_pix_t pix, got_e;
    rdr_pkg::rdr_pix_t colour_lookup_table [256];
    rdr_pkg::rdr_pix_t exp_q [$];
    logic [1:0]        end_q [$];
    logic [1:0]        got_end;
    int                last_v = -1;
    int                pclk_div = 1;
    int                n_errors = 0;
    int                n_compared = 0;
    int                cyc = 0;
    logic [7:0]        rst_idx [7] = '{`RDR_IDX_ROT_MODE, `RDR_IDX_STRIDE, `RDR_IDX_START_LO,
        `RDR_IDX_DISP_CTRL, `RDR_IDX_PANEL_W, `RDR_IDX_PANEL_H_LO, `RDR_IDX_SPLIT_LINE};
    logic [31:0]       rst_val [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h27, 32'hEF, 32'hFF};

    always #50 i_mclk = ~i_mclk;

    rdr_refresh uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr),
        .i_mem_data(mem_data), .o_pix_valid(pix_valid), .o_pix(pix), .o_line_end(line_end),
        .o_frame_end(frame_end));

    rdr_buf_model u_buf (.i_mclk(i_mclk), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
        .o_mem_data(mem_data));

    function automatic logic [7:0] buf_byte(input logic [16:0] a);
        return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
    endfunction

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1) @(posedge i_mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ba(idx), d, r, e);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic e);
        apb(1'b0, ba(idx), 32'h0, d, e);
    endtask

    // Expected stream is one frame of 2 lines by 8 pixels
    task automatic run_frame(input logic [7:0] ctrl, input logic [7:0] rot,
                             input logic [7:0] stride, input logic [16:0] start);
        logic [16:0]       a, seff;
        logic [7:0]        v;
        logic [31:0]       d;
        logic              er;
        rdr_pkg::rdr_pix_t e;
        int                bpp, ppb, sh;
        bpp = 1 << ctrl[2:1];
        ppb = 8 / bpp;
        seff = (stride == 8'h00) ? 17'h00100 : {9'h000, stride};
        // Pixel period in clocks; pixels only ever leave on its ticks
        pclk_div = !rot[7] ? 1 : (rot[6] && rot[1:0] == 2'h0) ? 2 : 1 << rot[1:0];
        last_v = -1;
        wr(`RDR_IDX_ROT_MODE, {24'h0, rot});
        wr(`RDR_IDX_STRIDE, {24'h0, stride});
        wr(`RDR_IDX_START_LO, {24'h0, start[7:0]});
        wr(`RDR_IDX_START_HI, {23'h0, start[16:8]});
        for (int l = 0; l < 2; l++)
            for (int k = 0; k < 8; k++)
            begin
                a = rot[7] ? 17'(start - l / ppb + k * seff)
                           : 17'(((ctrl[4] && l == 1) ? 0 : start + l * bpp) + k / ppb);
                sh = rot[7] ? bpp * (l % ppb) : 8 - bpp * (k % ppb + 1);
                v = (buf_byte(a) >> sh) & 8'((1 << bpp) - 1);
                e = colour_lookup_table[v];
                if (!ctrl[3])
                    e = '{e.green, e.green, e.green};
                if (ctrl[0])
                    e = ~e;
                exp_q.push_back(e);
                end_q.push_back({l == 1 && k == 7, k == 7});
            end
        wr(`RDR_IDX_DISP_CTRL, {24'h0, ctrl});
        do @(negedge i_mclk); while (frame_end !== 1'b1);
        wr(`RDR_IDX_DISP_CTRL, 32'h0);
        do rd(`RDR_IDX_STATUS, d, er); while (d[16] !== 1'b0);
        `RDR_CHK("pixels left", 0, exp_q.size())
        exp_q.delete();
        end_q.delete();
    endtask

    always @(negedge i_mclk)
        if (pix_valid === 1'b1 && exp_q.size() > 0)
        begin
            got_e = exp_q.pop_front();
            got_end = end_q.pop_front();
            `RDR_CHK("pixel", got_e, pix)
            `RDR_CHK("line and frame end", got_end, {frame_end, line_end})
            if (last_v >= 0)
                `RDR_CHK("pixel pacing", 0, (cyc - last_v) % pclk_div)
            last_v = cyc;
        end

    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        logic [31:0] d;
        logic        er;
        logic [16:0] s;
        d = $urandom(96118);
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        foreach (rst_idx[i])
        begin
            rd(rst_idx[i], d, er);
            `RDR_CHK("reset value", rst_val[i], d)
        end
        wr(`RDR_IDX_ROT_MODE, 32'hFF);
        rd(`RDR_IDX_ROT_MODE, d, er);
        `RDR_CHK("mode bits", 32'hC3, d)
        apb(1'b0, ba(8'h30), 32'h0, d, er);
        `RDR_CHK("unmapped err", 1'b1, er)
        `RDR_CHK("unmapped data", 32'h0, d)
        apb(1'b1, ba(`RDR_IDX_STRIDE) | 12'h001, 32'h55, d, er);
        `RDR_CHK("unaligned err", 1'b1, er)
        rd(`RDR_IDX_STRIDE, d, er);
        `RDR_CHK("stride kept", 32'h0, d)
        apb(1'b0, ba(`RDR_IDX_PANEL_W) | 12'h002, 32'h0, d, er);
        `RDR_CHK("unaligned read err", 1'b1, er)
        `RDR_CHK("unaligned read data", 32'h0, d)
        apb(1'b0, ba(`RDR_IDX_PANEL_W) | 12'h400, 32'h0, d, er);
        `RDR_CHK("high address err", 1'b1, er)
        `RDR_CHK("high address data", 32'h0, d)
        wr(`RDR_IDX_PANEL_W, 32'h0);
        wr(`RDR_IDX_PANEL_H_LO, 32'h1);
        wr(`RDR_IDX_LUT_INDEX, 32'h0);
        for (int i = 0; i < 256; i++)
        begin
            colour_lookup_table[i] = 12'($urandom);
            wr(`RDR_IDX_LUT_DATA, {20'h0, colour_lookup_table[i]});
        end
        wr(`RDR_IDX_LUT_INDEX, 32'h5);
        repeat (2)
        begin
            rd(`RDR_IDX_LUT_DATA, d, er);
            `RDR_CHK("table entry", {20'h0, colour_lookup_table[5]}, d)
        end
        s = 17'($urandom & 32'h7FFF);
        run_frame(8'h2F, 8'h40, 8'h00, s);
        run_frame(8'h24, 8'h00, 8'h00, s);
        run_frame(8'h21, 8'h00, 8'h00, s);
        run_frame(8'h2E, 8'h80, 8'h00, s);
        run_frame(8'h2E, 8'h80, 8'h00, s + 17'h00001);
        run_frame(8'h2E, 8'h81, 8'h40, s + 17'h00080);
        run_frame(8'h2C, 8'h80, 8'h80, s);
        run_frame(8'h2A, 8'h82, 8'h00, s);
        run_frame(8'h2E, 8'hC2, 8'hA0, s + 17'h000A0);
        run_frame(8'h2E, 8'hC0, 8'h03, s);
        wr(`RDR_IDX_SPLIT_LINE, 32'h1);
        run_frame(8'h3E, 8'h00, 8'h00, s);
        run_frame(8'h3E, 8'h83, 8'h00, s);
        print_verdict();
    end
endmodule // rotated_display_refresh_path_tb
